// ### src/sar_adc_conversion_serial_out.sv
// Conversion sequencing, auto power control and serial result output
`timescale 1ns/1ns

// Functional notes
// - Six serial modes: CS 3/4-wire, chain, busy option
// - Busy indicator bit precedes sixteen result bits
// - Conversion time fixed by internal clock
// - Input captured when conversion starts
// - Inputs isolated while converting
// - After conversion: reconnect, acquire, powered down, readable
// - Auto power-down at end of conversion
// - Auto wake-up at next conversion start
// - Straight binary sixteen-bit output coding
// - Full scale equals reference, step is ref/65536
// - Serial clock only shifts data after conversion
// - Select high at start picks CS mode
// - Start edge samples, converts, tristates output
// - CS plain frame: MSB on select, off after 16
// - CS busy frame: low bit, off after 17
module sar_adc_conversion_serial_out import sar_adc_pkg::*; (
  // Clock and reset
  input wire logic clock,
  input wire logic sys_rst,
  // Host pins
  input wire logic convert_start,
  input wire logic serial_in_select,
  input wire logic sclk,
  output logic serial_result_out,
  output logic serial_result_oe,
  // Analog front end: input level scaled by 65536/Vref
  input wire logic [16:0] analog_level,
  output logic inputs_isolated,
  output logic powered_down,
  output logic [15:0] last_result
);

  // ****************************************************************
  // Pin synchronisation
  // ****************************************************************
  logic [PIN_COUNT-1:0] pin_raw, pin_lvl, pin_rise, pin_fall;
  logic cs_lvl, si_lvl, cs_rise, sck_fall, selected, deselected;

  assign pin_raw = {sclk, serial_in_select, convert_start};

  pin_sync #(.W(PIN_COUNT)) u_pin_sync (
    .clock(clock),
    .sys_rst(sys_rst),
    .pins_raw(pin_raw),
    .lvl(pin_lvl),
    .rise(pin_rise),
    .fall(pin_fall)
  );

  assign cs_lvl = pin_lvl[PIN_CONV];
  assign si_lvl = pin_lvl[PIN_SEL];
  assign cs_rise = pin_rise[PIN_CONV];
  assign sck_fall = pin_fall[PIN_SCK];
  // Either start line (3-wire) or select line (4-wire) low acts as chip select
  assign selected = !cs_lvl || !si_lvl;
  assign deselected = cs_lvl && si_lvl;

  // ****************************************************************
  // Conversion sequencer
  // ****************************************************************
  stream_if #(.W(BUF_WIDTH)) conv_s ();
  stream_if #(.W(BUF_WIDTH)) tx_s ();

  conv_state_t conv_st_ff, nxt_conv_st;
  logic [CNT_W-1:0] cnt_ff, nxt_cnt;
  logic [15:0] sample_ff, nxt_sample, result_ff, nxt_result;
  logic chain_ff, nxt_chain, isolate_ff, nxt_isolate, pdn_ff, nxt_pdn;
  logic busy_pick;
  logic [15:0] quantized;

  // Clamp at positive full scale; the front end hands over Vin*65536/Vref
  assign quantized = (analog_level >= CODE_STEPS) ? CODE_MAX : analog_level[15:0];

  // Busy frame if selected at end of a CS conversion; chain uses the start line high
  assign busy_pick = chain_ff ? cs_lvl : selected;

  always_comb begin
    nxt_conv_st = conv_st_ff;
    nxt_cnt = cnt_ff;
    nxt_sample = sample_ff;
    nxt_result = result_ff;
    nxt_chain = chain_ff;
    nxt_isolate = isolate_ff;
    nxt_pdn = pdn_ff;
    conv_s.valid = 1'b0;
    conv_s.data = {chain_ff, busy_pick, sample_ff};
    unique case (conv_st_ff)
      CONV_ACQ: begin
        if (cs_rise) begin
          nxt_sample = quantized;
          nxt_chain = !si_lvl;
          nxt_cnt = CNT_RESET;
          nxt_isolate = 1'b1;
          nxt_pdn = 1'b0;
          nxt_conv_st = CONV_RUN;
        end
      end
      CONV_RUN: begin
        // Runs on the local clock only; start and serial clock are ignored here
        nxt_cnt = CNT_W'(cnt_ff + 8'h01);
        if (cnt_ff == CONV_LAST) begin
          nxt_result = sample_ff;
          nxt_isolate = 1'b0;
          nxt_pdn = 1'b1;
          nxt_conv_st = CONV_DONE;
        end
      end
      CONV_DONE: begin
        // Stalls here if the buffer is full rather than dropping the word
        conv_s.valid = 1'b1;
        if (conv_s.ready) begin
          nxt_conv_st = CONV_ACQ;
        end
      end
      default: begin
        // An illegal code drops back to acquisition
        nxt_conv_st = CONV_ACQ;
      end
    endcase
  end

  always_ff @(posedge clock) begin
    if (sys_rst) begin
      conv_st_ff <= CONV_ACQ;
      cnt_ff <= CNT_RESET;
      sample_ff <= CODE_RESET;
      result_ff <= CODE_RESET;
      chain_ff <= 1'b0;
      isolate_ff <= 1'b0;
      pdn_ff <= 1'b1;
    end else begin
      conv_st_ff <= nxt_conv_st;
      cnt_ff <= nxt_cnt;
      sample_ff <= nxt_sample;
      result_ff <= nxt_result;
      chain_ff <= nxt_chain;
      isolate_ff <= nxt_isolate;
      pdn_ff <= nxt_pdn;
    end
  end

  two_entry_buffer #(.W(BUF_WIDTH)) u_buffer (
    .clock(clock),
    .sys_rst(sys_rst),
    .in_s(conv_s),
    .out_s(tx_s)
  );

  // ****************************************************************
  // Serializer
  // ****************************************************************
  tx_state_t tx_st_ff, nxt_tx_st;
  logic [16:0] sh_ff, nxt_sh;
  logic [4:0] edges_ff, nxt_edges, limit_ff, nxt_limit;
  logic oe_ff, nxt_oe, chain_tx_ff, nxt_chain_tx;
  logic [4:0] edges_inc;

  assign edges_inc = 5'(edges_ff + 5'h01);

  always_comb begin
    nxt_tx_st = tx_st_ff;
    nxt_sh = sh_ff;
    nxt_edges = edges_ff;
    nxt_limit = limit_ff;
    nxt_oe = oe_ff;
    nxt_chain_tx = chain_tx_ff;
    tx_s.ready = (tx_st_ff == TX_OFF);
    unique case (tx_st_ff)
      TX_OFF: begin
        if (tx_s.valid) begin
          nxt_chain_tx = tx_s.data[W_CHAIN];
          nxt_edges = EDGES_RESET;
          if (tx_s.data[W_BUSY]) begin
            nxt_sh = {1'b0, tx_s.data[15:0]};
            nxt_limit = LIMIT_BUSY;
          end else begin
            nxt_sh = {tx_s.data[15:0], 1'b0};
            nxt_limit = LIMIT_PLAIN;
          end
          if (tx_s.data[W_BUSY] || tx_s.data[W_CHAIN]) begin
            nxt_oe = 1'b1;
            nxt_tx_st = TX_SHIFT;
          end else begin
            nxt_tx_st = TX_WAIT;
          end
        end
      end
      TX_WAIT: begin
        if (selected) begin
          nxt_oe = 1'b1;
          nxt_tx_st = TX_SHIFT;
        end
      end
      TX_SHIFT: begin
        if (!chain_tx_ff && deselected) begin
          nxt_oe = 1'b0;
          nxt_tx_st = TX_OFF;
        end else if (sck_fall) begin
          // Chain mode passes the upstream word on through the select pin
          nxt_sh = {sh_ff[15:0], chain_tx_ff && si_lvl};
          nxt_edges = edges_inc;
          if (!chain_tx_ff && edges_inc == limit_ff) begin
            nxt_oe = 1'b0;
            nxt_tx_st = TX_OFF;
          end
        end
      end
      default: begin
        // An illegal code drops back to idle with the pin released
        nxt_oe = 1'b0;
        nxt_tx_st = TX_OFF;
      end
    endcase
    if (cs_rise) begin
      // A new conversion abandons any frame still in progress
      nxt_oe = 1'b0;
      nxt_tx_st = TX_OFF;
    end
  end

  always_ff @(posedge clock) begin
    if (sys_rst) begin
      tx_st_ff <= TX_OFF;
      sh_ff <= SHIFT_RESET;
      edges_ff <= EDGES_RESET;
      limit_ff <= LIMIT_PLAIN;
      oe_ff <= 1'b0;
      chain_tx_ff <= 1'b0;
    end else begin
      tx_st_ff <= nxt_tx_st;
      sh_ff <= nxt_sh;
      edges_ff <= nxt_edges;
      limit_ff <= nxt_limit;
      oe_ff <= nxt_oe;
      chain_tx_ff <= nxt_chain_tx;
    end
  end

  assign serial_result_out = sh_ff[16];
  assign serial_result_oe = oe_ff;
  assign inputs_isolated = isolate_ff;
  assign powered_down = pdn_ff;
  assign last_result = result_ff;

  // ****************************************************************
  // Assertions
  // ****************************************************************
  localparam int CONV_CHK = CONV_CYCLES;
  localparam int CONV_END_DLY = CONV_CYCLES + 1;
  logic conv_start;
  assign conv_start = cs_rise && (conv_st_ff == CONV_ACQ);

  default clocking cb @(posedge clock); endclocking
  default disable iff (sys_rst);

  a_conv_fixed_len: assert property (conv_start |-> ##CONV_CHK (conv_st_ff == CONV_RUN)
    ##1 (conv_st_ff == CONV_DONE)) else $error("conversion length wrong");
  a_result_late: assert property (conv_start |-> ##CONV_END_DLY (last_result == sample_ff))
    else $error("result not presented after conversion");
  a_isolate_conv: assert property ((conv_st_ff == CONV_RUN) |-> inputs_isolated && !powered_down)
    else $error("inputs not isolated while converting");
  a_pdn_auto: assert property ($fell(conv_st_ff == CONV_RUN) |-> powered_down
    && !inputs_isolated) else $error("no power-down after conversion");
  a_wake_start: assert property (conv_start |=> !powered_down && inputs_isolated)
    else $error("no wake-up at conversion start");
  a_sample_capture: assert property (conv_start |=> sample_ff == $past(quantized))
    else $error("input not captured at start");
  a_code_clamp: assert property (conv_start && analog_level >= CODE_STEPS
    |=> sample_ff == CODE_MAX) else $error("full scale not clamped");
  a_mode_pick: assert property (conv_start |=> chain_ff == !$past(si_lvl))
    else $error("mode not taken from select line");
  a_hiz_start: assert property (cs_rise |=> !serial_result_oe)
    else $error("output not released at start");
  a_busy_first: assert property (tx_s.ready && tx_s.valid && tx_s.data[W_BUSY]
    && !cs_rise |=> serial_result_oe && !serial_result_out) else $error("busy bit not low");
  a_plain_end: assert property (tx_st_ff == TX_SHIFT && !chain_tx_ff && sck_fall
    && limit_ff == LIMIT_PLAIN && edges_ff == 5'h0F |=> !serial_result_oe)
    else $error("plain frame not ended after 16 edges");
  a_shift_sclk: assert property (tx_st_ff == TX_SHIFT && !sck_fall && !cs_rise
    |=> $stable(sh_ff)) else $error("data moved without serial clock");
  a_busy_end: assert property (tx_st_ff == TX_SHIFT && !chain_tx_ff && sck_fall
    && limit_ff == LIMIT_BUSY && edges_ff == 5'h10 |=> !serial_result_oe)
    else $error("busy frame not ended after 17 edges");
  a_deselect_off: assert property (tx_st_ff == TX_SHIFT && !chain_tx_ff && deselected
    |=> !serial_result_oe) else $error("output not released on deselect");
  a_select_msb: assert property (tx_st_ff == TX_WAIT && selected && !cs_rise
    |=> serial_result_oe && serial_result_out == last_result[15])
    else $error("MSB not presented on select");
  a_chain_hold: assert property (tx_st_ff == TX_SHIFT && chain_tx_ff && !cs_rise
    |=> serial_result_oe && tx_st_ff == TX_SHIFT) else $error("chain frame dropped");
  a_conv_steady: assert property (conv_st_ff == CONV_RUN && cnt_ff != CONV_LAST
    |=> conv_st_ff == CONV_RUN) else $error("conversion cut short");
  a_result_hold: assert property (!(conv_st_ff == CONV_RUN && cnt_ff == CONV_LAST)
    |=> $stable(last_result)) else $error("result changed outside conversion end");

  c_plain_frame: cover property (tx_st_ff == TX_SHIFT && limit_ff == LIMIT_PLAIN
    ##1 tx_st_ff == TX_OFF && !serial_result_oe);
  c_busy_frame: cover property (tx_st_ff == TX_SHIFT && limit_ff == LIMIT_BUSY
    && edges_ff == 5'h10 && sck_fall);
  c_chain_shift: cover property (tx_st_ff == TX_SHIFT && chain_tx_ff && sck_fall);
  c_full_scale: cover property (conv_start && analog_level >= CODE_STEPS);
  c_frame_abort: cover property (tx_st_ff == TX_SHIFT && cs_rise);
endmodule

// ### src/sar_adc_pkg.sv
// Shared constants and state types for the converter sequencing block
package sar_adc_pkg;

  // ****************************************************************
  // Timing
  // ****************************************************************
  localparam int CLK_PERIOD_NS = 10;
  localparam int T_CNV_NS = 1400;
  // Longest time, so the division rounds down
  localparam int CONV_CYCLES = T_CNV_NS / CLK_PERIOD_NS;
  localparam int CNT_W = 8;
  localparam logic [CNT_W-1:0] CONV_LAST = CNT_W'(CONV_CYCLES - 1);
  localparam logic [CNT_W-1:0] CNT_RESET = 8'h00;

  // ****************************************************************
  // Result coding
  // ****************************************************************
  localparam int RESULT_BITS = 16;
  localparam logic [15:0] CODE_MAX = 16'hFFFF;
  localparam logic [15:0] CODE_RESET = 16'h0000;
  localparam logic [16:0] CODE_STEPS = 17'h1_0000;

  // ****************************************************************
  // Serial frame
  // ****************************************************************
  localparam logic [4:0] LIMIT_PLAIN = 5'h10;
  localparam logic [4:0] LIMIT_BUSY = 5'h11;
  localparam logic [4:0] EDGES_RESET = 5'h00;
  localparam logic [16:0] SHIFT_RESET = 17'h0_0000;

  // ****************************************************************
  // Buffered word layout: {chain, busy, code}
  // ****************************************************************
  localparam int BUF_WIDTH = 18;
  localparam int BUF_DEPTH = 2;
  localparam int W_CHAIN = 17;
  localparam int W_BUSY = 16;
  localparam logic [BUF_WIDTH-1:0] WORD_RESET = 18'h0_0000;

  // ****************************************************************
  // Pin synchroniser
  // ****************************************************************
  localparam int PIN_COUNT = 3;
  localparam int PIN_CONV = 0;
  localparam int PIN_SEL = 1;
  localparam int PIN_SCK = 2;
  localparam logic [1:0] PRIME_RESET = 2'h0;
  localparam logic [1:0] PRIME_DONE = 2'h3;

  // ****************************************************************
  // State types
  // ****************************************************************
  typedef enum logic [2:0] {
    CONV_ACQ = 3'h1,
    CONV_RUN = 3'h2,
    CONV_DONE = 3'h4
  } conv_state_t;

  typedef enum logic [2:0] {
    TX_OFF = 3'h1,
    TX_WAIT = 3'h2,
    TX_SHIFT = 3'h4
  } tx_state_t;

endpackage

// ### src/stream_if.sv
// Valid/ready word stream between converter core, buffer and serializer
`timescale 1ns/1ns
interface stream_if #(parameter int W = 18);
  logic valid;
  logic ready;
  logic [W-1:0] data;
  modport source(output valid, output data, input ready);
  modport sink(input valid, input data, output ready);
endinterface

// ### src/pin_sync.sv
// Three-stage pin synchroniser with agreement filter and edge pulses
`timescale 1ns/1ns
module pin_sync import sar_adc_pkg::*; #(parameter int W = 1) (
  // Clock and reset
  input wire logic clock,
  input wire logic sys_rst,
  // Raw pins and filtered view
  input wire logic [W-1:0] pins_raw,
  output logic [W-1:0] lvl,
  output logic [W-1:0] rise,
  output logic [W-1:0] fall
);
  logic [W-1:0] s1_ff, s2_ff, s3_ff, lvl_ff, rise_ff, fall_ff;
  logic [W-1:0] nxt_lvl, nxt_rise, nxt_fall, agree;
  logic [1:0] prime_ff, nxt_prime;

  // Level is preloaded from stage two while priming, so that a pin already high
  // at release has the same value in level and stage three and gives no edge
  always_comb begin
    agree = ~(s2_ff ^ s3_ff);
    nxt_prime = prime_ff;
    nxt_lvl = lvl_ff;
    nxt_rise = '0;
    nxt_fall = '0;
    if (prime_ff != PRIME_DONE) begin
      nxt_prime = 2'(prime_ff + 2'h1);
      nxt_lvl = s2_ff;
    end else begin
      nxt_lvl = (agree & s3_ff) | (~agree & lvl_ff);
      nxt_rise = nxt_lvl & ~lvl_ff;
      nxt_fall = ~nxt_lvl & lvl_ff;
    end
  end

  always_ff @(posedge clock) begin
    if (sys_rst) begin
      s1_ff <= '0;
      s2_ff <= '0;
      s3_ff <= '0;
      lvl_ff <= '0;
      rise_ff <= '0;
      fall_ff <= '0;
      prime_ff <= PRIME_RESET;
    end else begin
      s1_ff <= pins_raw;
      s2_ff <= s1_ff;
      s3_ff <= s2_ff;
      lvl_ff <= nxt_lvl;
      rise_ff <= nxt_rise;
      fall_ff <= nxt_fall;
      prime_ff <= nxt_prime;
    end
  end

  assign lvl = lvl_ff;
  assign rise = rise_ff;
  assign fall = fall_ff;
endmodule

// ### src/two_entry_buffer.sv
// Two-entry valid/ready buffer with registered storage
`timescale 1ns/1ns
module two_entry_buffer import sar_adc_pkg::*; #(parameter int W = BUF_WIDTH) (
  // Clock and reset
  input wire logic clock,
  input wire logic sys_rst,
  // Streams
  stream_if.sink in_s,
  stream_if.source out_s
);
  logic [W-1:0] mem_ff [BUF_DEPTH];
  logic [W-1:0] nxt_mem [BUF_DEPTH];
  logic wr_ff, rd_ff, nxt_wr, nxt_rd;
  logic [1:0] cnt_ff, nxt_cnt;
  logic push, pop;

  always_comb begin
    push = in_s.valid && (cnt_ff != 2'h2);
    pop = out_s.ready && (cnt_ff != 2'h0);
    nxt_mem = mem_ff;
    nxt_wr = wr_ff;
    nxt_rd = rd_ff;
    if (push) begin
      nxt_mem[wr_ff] = in_s.data;
      nxt_wr = ~wr_ff;
    end
    if (pop) begin
      nxt_rd = ~rd_ff;
    end
    nxt_cnt = 2'(cnt_ff + {1'b0, push} - {1'b0, pop});
  end

  always_ff @(posedge clock) begin
    if (sys_rst) begin
      mem_ff[0] <= '0;
      mem_ff[1] <= '0;
      wr_ff <= 1'b0;
      rd_ff <= 1'b0;
      cnt_ff <= 2'h0;
    end else begin
      mem_ff <= nxt_mem;
      wr_ff <= nxt_wr;
      rd_ff <= nxt_rd;
      cnt_ff <= nxt_cnt;
    end
  end

  assign in_s.ready = (cnt_ff != 2'h2);
  assign out_s.valid = (cnt_ff != 2'h0);
  assign out_s.data = mem_ff[rd_ff];

  a_buf_bound: assert property (@(posedge clock) disable iff (sys_rst)
    cnt_ff != 2'h3) else $error("buffer count out of range");
endmodule

// ### tb/host_model.sv
// Serial master model that drives the converter pins and collects frames
`timescale 1ns/1ns
module host_model (
  // Clock
  input wire logic clock,
  // Pins towards the converter
  output logic convert_start,
  output logic serial_in_select,
  output logic sclk,
  input wire logic serial_result_out,
  input wire logic serial_result_oe,
  // Collected frame
  output logic [16:0] word,
  output logic word_stb
);
  logic last_bit;
  logic wire_lvl;

  initial begin
    convert_start = 1'b0;
    serial_in_select = 1'b1;
    sclk = 1'b1;
    word = 17'h0_0000;
    word_stb = 1'b0;
    last_bit = 1'b0;
  end

  // No pull resistor: a released line shows the inverse of its last value
  always @(serial_result_out or serial_result_oe) begin
    if (serial_result_oe === 1'b1) begin
      last_bit = serial_result_out;
    end
  end
  assign wire_lvl = (serial_result_oe === 1'b1) ? serial_result_out : ~last_bit;

  // Caller aligns the change just after a clock edge
  task automatic pins(input logic cs, input logic sel);
    convert_start = cs;
    serial_in_select = sel;
  endtask

  // Clock runs only here, after the conversion is over, so it never disturbs one
  task automatic read_frame(input int n);
    logic [16:0] w;
    w = 17'h0_0000;
    for (int i = n - 1; i >= 0; i--) begin
      // Sampled just before the fall: the bit only moves well after it
      w[i] = wire_lvl;
      sclk = 1'b0;
      #62;
      sclk = 1'b1;
      #63;
    end
    word = w;
    word_stb = 1'b1;
    #1;
    word_stb = 1'b0;
  endtask
endmodule

// ### tb/tb.sv
// Self-checking bench: five serial modes (no chain busy frame), coding boundaries and conversion timing
`timescale 1ns/1ns
`define chk(g, e) begin n_checks++; if ((g) !== (e)) begin err_total++; \
  $display("BAD %0t got %h exp %h", $time, g, e); end end
module tb;
  import sar_adc_pkg::*;
  logic clock;
  logic sys_rst;
  logic convert_start;
  logic serial_in_select;
  logic sclk;
  logic serial_result_out;
  logic serial_result_oe;
  logic [16:0] analog_level;
  logic inputs_isolated;
  logic powered_down;
  logic [15:0] last_result;
  logic [16:0] word;
  logic word_stb;
  logic [16:0] exp_w;
  logic [16:0] exp_q[$];
  int err_total = 0;
  int n_checks = 0;
  integer seed = 32'hff8b_dfbe;

  // ****************************************************************
  // Clock, design and host
  // ****************************************************************
  initial clock = 1'b0;
  always #5 clock = ~clock;

  sar_adc_conversion_serial_out uut (
    .clock(clock), .sys_rst(sys_rst), .convert_start(convert_start),
    .serial_in_select(serial_in_select), .sclk(sclk),
    .serial_result_out(serial_result_out), .serial_result_oe(serial_result_oe),
    .analog_level(analog_level), .inputs_isolated(inputs_isolated),
    .powered_down(powered_down), .last_result(last_result)
  );

  host_model host (
    .clock(clock), .convert_start(convert_start), .serial_in_select(serial_in_select),
    .sclk(sclk), .serial_result_out(serial_result_out),
    .serial_result_oe(serial_result_oe), .word(word), .word_stb(word_stb)
  );

  // ****************************************************************
  // Frame monitor
  // ****************************************************************
  always @(posedge word_stb) begin
    if (exp_q.size() == 0) begin
      err_total++;
      $display("BAD %0t frame without a pending expectation", $time);
    end else begin
      exp_w = exp_q.pop_front();
      `chk(word, exp_w)
    end
  end

  task automatic tick(input int n);
    repeat (n) @(posedge clock);
    #1;
  endtask

  task automatic summarize();
    if (err_total == 0 && n_checks > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask

  // Modes: 0/1 three-wire plain/busy, 2/3 four-wire plain/busy, 4 chain.
  // A non-zero cut reads that many bits, then deselects in four-wire mode.
  task automatic run(input int mode, input logic [16:0] lvl, input int cut);
    logic chain;
    logic four;
    logic busy;
    logic [15:0] code;
    int cnt;
    int nbits;
    chain = (mode == 4);
    four = (mode == 2) || (mode == 3);
    busy = (mode == 1) || (mode == 3);
    code = lvl[16] ? CODE_MAX : lvl[15:0];
    nbits = (cut > 0) ? cut : (busy ? 17 : 16);
    cnt = 0;
    analog_level = lvl;
    host.pins(1'b0, !chain);
    tick(6);
    host.pins(1'b1, !chain);
    for (int i = 0; i < 300 && !(cnt > 0 && powered_down === 1'b1); i++) begin
      tick(1);
      if (inputs_isolated === 1'b1) cnt++;
      if (i == 20) begin
        // Input moves after the start: the captured value must not follow it
        analog_level = ~lvl;
        host.pins(!(mode == 1 || chain), !(mode == 3 || chain));
        `chk(inputs_isolated, 1'b1)
        `chk(powered_down, 1'b0)
        `chk(serial_result_oe, 1'b0)
      end
    end
    if (powered_down !== 1'b1) begin
      err_total++;
      $display("BAD %0t conversion never ended", $time);
      summarize();
    end
    `chk(cnt, CONV_CYCLES)
    `chk(last_result, code)
    `chk(inputs_isolated, 1'b0)
    `chk(powered_down, 1'b1)
    exp_q.push_back(({1'b0, code}) >> (busy ? 0 : 16 - nbits));
    tick(4);
    if (!busy && !chain) begin
      `chk(serial_result_oe, 1'b0)
      host.pins(four, !four);
      tick(7);
    end
    `chk(serial_result_oe, 1'b1)
    host.read_frame(nbits);
    if (cut > 0) begin
      host.pins(1'b1, 1'b1);
      tick(7);
      `chk(serial_result_oe, 1'b0)
    end else begin
      tick(2);
      `chk(serial_result_oe, chain)
    end
  endtask

  // ****************************************************************
  // Main sequence
  // ****************************************************************
  initial begin
    sys_rst = 1'b1;
    analog_level = 17'h0_0000;
    repeat (8) @(posedge clock);
    #1;
    sys_rst = 1'b0;
    tick(6);
    `chk(powered_down, 1'b1)
    `chk(last_result, CODE_RESET)
    `chk(serial_result_oe, 1'b0)
    run(0, 17'h0_0000, 0);
    run(1, 17'h0_8000, 0);
    run(2, 17'h0_7fff, 0);
    run(3, 17'h0_ffff, 0);
    run(4, 17'h1_2345, 0);
    run(2, 17'h0_a5c3, 8);
    for (int k = 0; k < 5; k++) begin
      run(k, {1'b0, 16'($random(seed))}, 0);
    end
    tick(10);
    if (exp_q.size() != 0) begin
      err_total++;
      $display("BAD %0t frames missing", $time);
    end
    // Reset in mid-run with the start line already high: no conversion may follow
    host.pins(1'b1, 1'b1);
    tick(2);
    sys_rst = 1'b1;
    tick(2);
    sys_rst = 1'b0;
    tick(20);
    `chk(powered_down, 1'b1)
    `chk(inputs_isolated, 1'b0)
    `chk(serial_result_oe, 1'b0)
    `chk(last_result, CODE_RESET)
    summarize();
  end
endmodule
